// ==== csth_defs.svh ====
`ifndef CSTH_DEFS_SVH
`define CSTH_DEFS_SVH

// synchroniser bit positions
`define CSTH_SY_PARK  0
`define CSTH_SY_SMI   1
`define CSTH_SY_TRIP  2
`define CSTH_SY_TCK   3
`define CSTH_SY_TDI   4
`define CSTH_SY_W     5

// idle pin levels: park and smi high (inactive), others low
`define CSTH_SY_RST   5'h03

// edges after reset release before the smi strap is sampled
`define CSTH_STRAP_WAIT 2'h2
`define CSTH_CNT_RST    2'h0
`define CSTH_CNT_ONE    2'h1

`endif

// ==== csth_pkg.sv ====
package csth_pkg;

  typedef enum logic [4:0] {
    CSTH_RUN      = 5'h01,
    CSTH_PARK_ACK = 5'h02,
    CSTH_PARKED   = 5'h04,
    CSTH_RESUME   = 5'h08,
    CSTH_THERM    = 5'h10
  } csth_state_e;

  typedef logic [1:0] csth_cnt_t;

endpackage

// ==== csth_clock_halt.sv ====
// Overview of operation
// - park request asserted enters clock-parked state
// - entering park issues bus acknowledge transaction
// - parked gates all clocks except bus, interrupt
// - parked still snoops bus and services interrupts
// - request removed: clocks on, then execute
// - park request asynchronous, never touches bus clock
// - smi held at reset release floats outputs
// - thermal trip stops clocks and halts execution
// - thermal trip output stays latched
// - reset releases thermal latch, trips again if hot
// - test port: tck clocks, tdi in, tdo out
`timescale 1ns/1ps
`include "csth_defs.svh"

module csth_clock_halt
  import csth_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // platform pins
  input  wire logic clock_park_request_n_i,
  input  wire logic sys_mgmt_interrupt_n_i,
  input  wire logic thermal_sense_i,
  // front side bus unit handshake
  input  wire logic park_ack_taken_i,
  output logic      park_ack_req_o,
  // clock gates and core control
  output logic      core_clk_en_o,
  output logic      fsb_clk_en_o,
  output logic      lic_clk_en_o,
  output logic      exec_en_o,
  output logic      snoop_en_o,
  output logic      irq_service_en_o,
  // thermal shutdown open-drain pin
  output logic      thermal_shutdown_n_o,
  output logic      thermal_shutdown_oe_o,
  // output float strap
  output logic      outputs_hiz_o,
  // test access port
  input  wire logic tck_i,
  input  wire logic tdi_i,
  output logic      tdo_o,
  output logic      tdo_oe_o
);

  logic [`CSTH_SY_W-1:0] sync1_reg;
  logic [`CSTH_SY_W-1:0] sync2_reg;
  logic                  park_req;
  logic                  smi_act;
  logic                  trip_s;
  logic                  tck_s;
  logic                  tdi_s;

  // every platform and test pin is foreign to clk_i; first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= `CSTH_SY_RST;
      sync2_reg <= `CSTH_SY_RST;
    end else begin
      sync1_reg <= {tdi_i, tck_i, thermal_sense_i,
                    sys_mgmt_interrupt_n_i, clock_park_request_n_i};
      sync2_reg <= sync1_reg;
    end
  end

  assign park_req = ~sync2_reg[`CSTH_SY_PARK];
  assign smi_act  = ~sync2_reg[`CSTH_SY_SMI];
  assign trip_s   = sync2_reg[`CSTH_SY_TRIP];
  assign tck_s    = sync2_reg[`CSTH_SY_TCK];
  assign tdi_s    = sync2_reg[`CSTH_SY_TDI];

  // reset-release strap capture
  csth_cnt_t cnt_reg;
  csth_cnt_t cnt_next;
  logic      strap_done_reg;
  logic      strap_done_next;
  logic      hiz_reg;
  logic      hiz_next;

  // smi is sampled only once it has crossed the synchroniser,
  // so the strap sees the level held across the release
  always_comb begin
    cnt_next        = cnt_reg;
    strap_done_next = strap_done_reg;
    hiz_next        = hiz_reg;
    if (!strap_done_reg) begin
      if (cnt_reg == `CSTH_STRAP_WAIT) begin
        strap_done_next = 1'b1;
        hiz_next        = smi_act;
      end else begin
        cnt_next = cnt_reg + `CSTH_CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg        <= `CSTH_CNT_RST;
      strap_done_reg <= 1'b0;
      hiz_reg        <= 1'b0;
    end else begin
      cnt_reg        <= cnt_next;
      strap_done_reg <= strap_done_next;
      hiz_reg        <= hiz_next;
    end
  end

  // park and thermal state machine
  csth_state_e state_reg;
  csth_state_e state_next;
  logic        ack_next;
  logic        core_next;
  logic        fsb_next;
  logic        lic_next;
  logic        exec_next;
  logic        snoop_next;
  logic        irq_next;
  logic        trip_next;
  logic        ack_reg;
  logic        core_reg;
  logic        fsb_reg;
  logic        lic_reg;
  logic        exec_reg;
  logic        snoop_reg;
  logic        irq_reg;
  logic        trip_reg;

  always_comb begin
    state_next = state_reg;
    trip_next  = trip_reg;
    if (trip_s) begin
      trip_next = 1'b1;
    end
    // thermal wins over everything and only reset leaves it
    if (trip_s || trip_reg) begin
      state_next = CSTH_THERM;
    end else begin
      unique case (state_reg)
        CSTH_RUN: begin
          if (park_req) begin
            state_next = CSTH_PARK_ACK;
          end
        end
        CSTH_PARK_ACK: begin
          // the grant is finished even if the request drops meanwhile
          if (park_ack_taken_i) begin
            state_next = CSTH_PARKED;
          end
        end
        CSTH_PARKED: begin
          if (!park_req) begin
            state_next = CSTH_RESUME;
          end
        end
        CSTH_RESUME: begin
          state_next = CSTH_RUN;
        end
        CSTH_THERM: begin
          state_next = CSTH_THERM;
        end
      endcase
    end
    // outputs follow the next state so they line up with state_reg
    ack_next   = (state_next == CSTH_PARK_ACK);
    core_next  = (state_next == CSTH_RUN) ||
                 (state_next == CSTH_PARK_ACK) ||
                 (state_next == CSTH_RESUME);
    // bus and interrupt units lose their clock only on thermal trip
    fsb_next   = (state_next != CSTH_THERM);
    lic_next   = (state_next != CSTH_THERM);
    exec_next  = (state_next == CSTH_RUN);
    snoop_next = (state_next != CSTH_THERM);
    irq_next   = (state_next != CSTH_THERM);
  end

  // asynchronous reset clears the thermal latch even while hot
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= CSTH_RUN;
      trip_reg  <= 1'b0;
      ack_reg   <= 1'b0;
      core_reg  <= 1'b1;
      fsb_reg   <= 1'b1;
      lic_reg   <= 1'b1;
      exec_reg  <= 1'b1;
      snoop_reg <= 1'b1;
      irq_reg   <= 1'b1;
    end else begin
      state_reg <= state_next;
      trip_reg  <= trip_next;
      ack_reg   <= ack_next;
      core_reg  <= core_next;
      fsb_reg   <= fsb_next;
      lic_reg   <= lic_next;
      exec_reg  <= exec_next;
      snoop_reg <= snoop_next;
      irq_reg   <= irq_next;
    end
  end

  // test access port, bypass path sampled on clk_i
  logic tck_prev_reg;
  logic tck_prev_next;
  logic byp_reg;
  logic byp_next;
  logic tdo_reg;
  logic tdo_next;
  logic tdo_oe_reg;
  logic tdo_oe_next;

  // tck is oversampled, so it must run well below clk_i
  always_comb begin
    tck_prev_next = tck_s;
    byp_next      = byp_reg;
    tdo_next      = tdo_reg;
    if (tck_s && !tck_prev_reg) begin
      byp_next = tdi_s;
    end
    if (!tck_s && tck_prev_reg) begin
      tdo_next = byp_reg;
    end
    tdo_oe_next = strap_done_next && !hiz_next;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tck_prev_reg <= 1'b0;
      byp_reg      <= 1'b0;
      tdo_reg      <= 1'b0;
      tdo_oe_reg   <= 1'b0;
    end else begin
      tck_prev_reg <= tck_prev_next;
      byp_reg      <= byp_next;
      tdo_reg      <= tdo_next;
      tdo_oe_reg   <= tdo_oe_next;
    end
  end

  // thermal pin drives low only when latched and not floated
  logic tpin_oe_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tpin_oe_reg <= 1'b0;
    end else begin
      tpin_oe_reg <= trip_next && !hiz_next;
    end
  end

  assign park_ack_req_o        = ack_reg;
  assign core_clk_en_o         = core_reg;
  assign fsb_clk_en_o          = fsb_reg;
  assign lic_clk_en_o          = lic_reg;
  assign exec_en_o             = exec_reg;
  assign snoop_en_o            = snoop_reg;
  assign irq_service_en_o      = irq_reg;
  assign thermal_shutdown_n_o  = 1'b0;
  assign thermal_shutdown_oe_o = tpin_oe_reg;
  assign outputs_hiz_o         = hiz_reg;
  assign tdo_o                 = tdo_reg;
  assign tdo_oe_o              = tdo_oe_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence park_seen_s;
    park_req && !trip_s && (state_reg == CSTH_RUN);
  endsequence

  sequence parked_exit_s;
    (state_reg == CSTH_PARKED) && !park_req && !trip_s;
  endsequence

  sequence tck_rise_s;
    tck_s && !tck_prev_reg;
  endsequence

  park_entry_a : assert property (
    park_seen_s |=> (state_reg == CSTH_PARK_ACK) && park_ack_req_o)
    else $error("park request did not start the grant");

  grant_ack_a : assert property (
    (state_reg == CSTH_PARK_ACK) && park_ack_taken_i && !trip_s
      |=> !park_ack_req_o && (state_reg == CSTH_PARKED))
    else $error("grant acknowledge not completed");

  parked_gate_a : assert property (
    (state_reg == CSTH_PARKED)
      |-> !core_clk_en_o && fsb_clk_en_o && lic_clk_en_o && !exec_en_o)
    else $error("wrong clock gating while parked");

  parked_snoop_a : assert property (
    (state_reg == CSTH_PARKED) |-> snoop_en_o && irq_service_en_o)
    else $error("snoop or interrupt lost while parked");

  resume_order_a : assert property (
    parked_exit_s |=> core_clk_en_o && !exec_en_o
      ##1 (exec_en_o || (state_reg == CSTH_THERM)))
    else $error("clocks not restored before execution");

  bus_clock_a : assert property (
    park_req && !trip_reg && !trip_s |=> fsb_clk_en_o)
    else $error("park request touched the bus clock");

  float_hold_a : assert property (
    outputs_hiz_o |=> outputs_hiz_o && !tdo_oe_o && !thermal_shutdown_oe_o)
    else $error("floated outputs driven again");

  therm_stop_a : assert property (
    trip_s |=> !core_clk_en_o && !exec_en_o && !fsb_clk_en_o
      && !lic_clk_en_o)
    else $error("thermal trip did not stop the core");

  trip_latch_a : assert property (
    (state_reg == CSTH_THERM) |=> (state_reg == CSTH_THERM)
      && (thermal_shutdown_oe_o == !outputs_hiz_o))
    else $error("thermal latch released without reset");

  tap_shift_a : assert property (
    tck_rise_s ##1 tck_s[*2] ##1 !tck_s |=> tdo_o == $past(tdi_s, 4))
    else $error("test data not shifted through bypass");

  sync_depth_a : assert property (
    $rose(park_req) |-> !$past(clock_park_request_n_i, 2))
    else $error("park request skipped a synchroniser stage");

endmodule

// ==== csth_platform.sv ====
`timescale 1ns/1ps
module csth_platform (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // grant wait chosen by the bench, 0 = prompt
  input  wire logic [3:0] ack_delay_i,
  // device side
  input  wire logic       park_ack_req_i,
  input  wire logic       thermal_shutdown_oe_i,
  output logic            park_ack_taken_o,
  output logic            power_off_o
);
  logic [3:0] wait_reg;
  logic [3:0] wait_next;
  logic       taken_reg;
  logic       taken_next;
  logic       off_reg;
  logic       off_next;

  // one pulse per request; guard stops a second pulse while req drops
  always_comb begin
    wait_next  = park_ack_req_i ? wait_reg + 4'h1 : 4'h0;
    taken_next = park_ack_req_i && !taken_reg &&
                 wait_reg >= ack_delay_i;
    off_next   = off_reg | thermal_shutdown_oe_i;
  end

  // power flag clears on reset, standing in for a power cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_reg  <= 4'h0;
      taken_reg <= 1'b0;
      off_reg   <= 1'b0;
    end else begin
      wait_reg  <= wait_next;
      taken_reg <= taken_next;
      off_reg   <= off_next;
    end
  end

  assign park_ack_taken_o = taken_reg;
  assign power_off_o      = off_reg;
endmodule

// ==== core_clock_stop_and_thermal_halt_tb.sv ====
`timescale 1ns/1ps
module core_clock_stop_and_thermal_halt_tb;
  logic       clk_i;
  logic       rst_n_i;
  logic       park_n;
  logic       smi_n;
  logic       sense;
  logic       tck;
  logic       tdi;
  logic       taken;
  logic       off;
  logic [3:0] delay;
  logic       ack_req;
  logic       core_en;
  logic       fsb_en;
  logic       lic_en;
  logic       exec_en;
  logic       snoop_en;
  logic       irq_en;
  logic       trip_n;
  logic       trip_oe;
  logic       hiz;
  logic       tdo;
  logic       tdo_oe;
  int         fails;
  int         compares;
  int         cycles;
  wire  [5:0] ens = {core_en, fsb_en, lic_en, exec_en, snoop_en, irq_en};

  csth_clock_halt dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .clock_park_request_n_i(park_n),
    .sys_mgmt_interrupt_n_i(smi_n), .thermal_sense_i(sense),
    .park_ack_taken_i(taken), .park_ack_req_o(ack_req),
    .core_clk_en_o(core_en), .fsb_clk_en_o(fsb_en), .lic_clk_en_o(lic_en),
    .exec_en_o(exec_en), .snoop_en_o(snoop_en), .irq_service_en_o(irq_en),
    .thermal_shutdown_n_o(trip_n), .thermal_shutdown_oe_o(trip_oe),
    .outputs_hiz_o(hiz), .tck_i(tck), .tdi_i(tdi), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe));

  csth_platform plat_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ack_delay_i(delay),
    .park_ack_req_i(ack_req), .thermal_shutdown_oe_i(trip_oe),
    .park_ack_taken_o(taken), .power_off_o(off));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // run should take about 130 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      close_out();
    end
  end

  task close_out;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wt(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 60) begin
      @(negedge clk_i);
      n++;
    end
    check({7'h0, s}, {7'h0, v});
  endtask

  task do_reset(input logic smi, input logic hot);
    @(negedge clk_i);
    rst_n_i = 1'b0;
    smi_n = smi;
    sense = hot;
    park_n = 1'b1;
    repeat (2) @(negedge clk_i);
    check({trip_oe, hiz, ens}, 8'h3f);
    repeat (4) @(negedge clk_i);
    rst_n_i = 1'b1;
  endtask

  task test_reset;
    do_reset(1'b1, 1'b0);
    repeat (5) @(negedge clk_i);
    check({3'h0, ack_req, trip_oe, hiz, tdo_oe, trip_n}, 8'h02);
    $display("test reset done");
  endtask

  task test_park(input logic [3:0] d);
    delay = d;
    @(negedge clk_i);
    park_n = 1'b0;
    @(negedge clk_i);
    check({7'h0, ack_req}, 8'h00);
    wt(ack_req, 1'b1);
    check({2'h0, ens}, 8'h3b);
    wt(core_en, 1'b0);
    check({1'b0, ack_req, ens}, 8'h1b);
    @(negedge clk_i);
    park_n = 1'b1;
    wt(core_en, 1'b1);
    check({7'h0, exec_en}, 8'h00);
    @(negedge clk_i);
    check({2'h0, ens}, 8'h3f);
    $display("test park delay %0d done", d);
  endtask

  task test_tap;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i);
      tdi = (i != 1);
      tck = 1'b1;
      repeat (3) @(negedge clk_i);
      tck = 1'b0;
      repeat (5) @(negedge clk_i);
      check({6'h0, tdo_oe, tdo}, {7'h1, tdi});
    end
    $display("test tap done");
  endtask

  task test_strap;
    do_reset(1'b0, 1'b0);
    repeat (4) @(negedge clk_i);
    smi_n = 1'b1;
    repeat (4) @(negedge clk_i);
    check({6'h0, hiz, tdo_oe}, 8'h02);
    do_reset(1'b1, 1'b0);
    $display("test strap done");
  endtask

  task test_thermal;
    @(negedge clk_i);
    sense = 1'b1;
    wt(trip_oe, 1'b1);
    check({1'b0, trip_n, ens}, 8'h00);
    @(negedge clk_i);
    sense = 1'b0;
    park_n = 1'b0;
    repeat (10) @(negedge clk_i);
    check({off, trip_oe, ens}, 8'hc0);
    do_reset(1'b1, 1'b1);
    wt(trip_oe, 1'b1);
    do_reset(1'b1, 1'b0);
    $display("test thermal done");
  endtask

  initial begin
    fails = 0;
    compares = 0;
    cycles = 0;
    rst_n_i = 1'b0;
    park_n = 1'b1;
    smi_n = 1'b1;
    sense = 1'b0;
    tck = 1'b0;
    tdi = 1'b0;
    delay = 4'h0;
    test_reset();
    test_park(4'h0);
    test_park(4'h5);
    test_tap();
    test_strap();
    test_thermal();
    close_out();
  end
endmodule
